// >>> hdl/lri_pkg.sv
// Shared constants of the eight-channel receive output interface.
// Assumes a 200 MHz core clock that also serves as the internal master clock.
package lri_pkg;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LOS = 8'h04;
    localparam logic [7:0] REG_INT_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_CLEAR = 8'h0C;
    localparam logic [7:0] REG_INT_ENABLE = 8'h10;
    localparam logic [7:0] REG_CNT_RESET = 8'h14;
    localparam logic [7:0] REG_SAT = 8'h18;

    localparam int unsigned CTRL_EDGE_BIT = 0;
    localparam int unsigned CTRL_SINGLE_BIT = 1;
    localparam int unsigned CTRL_OVF_BIT = 2;
    localparam logic [7:0] CTRL_MASK = 8'h07;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] INT_ENABLE_RESET = 8'h00;

    localparam int unsigned CORE_CLK_PERIOD_PS = 5000;
    localparam int unsigned LINE_BIT_PERIOD_PS = 648000;
    localparam int unsigned BIT_DIV = LINE_BIT_PERIOD_PS / CORE_CLK_PERIOD_PS;
    localparam int unsigned PH_W = 8;
    localparam int unsigned LOS_ZEROS = 175;
    localparam int unsigned EXZ_LIMIT = 15;
    localparam int unsigned ZERO_W = 8;
    localparam int unsigned CNT_W = 16;
endpackage

// >>> hdl/lri_chan_if.sv
// Per-channel link between the clock recovery top and one output channel.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface lri_chan_if;
    logic strobe;
    logic fall;
    logic bit_pos;
    logic bit_neg;
    logic rx_en;
    logic edge_sel;
    logic single_rail;
    logic ovf_sel;
    logic cnt_clr;
    logic pos_out;
    logic neg_out;
    logic los;
    logic sat;

    modport top
    (
        output strobe, fall, bit_pos, bit_neg, rx_en, edge_sel, single_rail, ovf_sel, cnt_clr,
        input pos_out, neg_out, los, sat
    );
    modport chan
    (
        input strobe, fall, bit_pos, bit_neg, rx_en, edge_sel, single_rail, ovf_sel, cnt_clr,
        output pos_out, neg_out, los, sat
    );
endinterface // lri_chan_if

// >>> hdl/lri_channel.sv
// One receive channel: bit decode, violation counting, loss detection, output registers.
// Assumes strobe marks the recovered rising edge with the finished bit, fall the falling edge.
`timescale 1ns/100ps
module lri_channel #(
    parameter int unsigned LOS_ZEROS = lri_pkg::LOS_ZEROS,
    parameter int unsigned EXZ_LIMIT = lri_pkg::EXZ_LIMIT,
    parameter int unsigned CNT_W = lri_pkg::CNT_W
)(
    input wire logic core_clk,
    input wire logic rst_n,
    lri_chan_if.chan ch
);
    localparam int unsigned ZW = lri_pkg::ZERO_W;
    localparam logic [ZW-1:0] ZMAX = '1;
    localparam logic [ZW-1:0] LOS_CNT = ZW'(LOS_ZEROS - 1);
    localparam logic [ZW-1:0] EXZ_CNT = ZW'(EXZ_LIMIT);

    typedef struct packed {
        logic last_neg;
        logic has_mark;
        logic [ZW-1:0] zeros;
        logic [CNT_W-1:0] cnt;
        logic pend_pos;
        logic pend_neg;
        logic pend_los;
        logic pos_out;
        logic neg_out;
        logic los;
    } lri_chan_state_t;

    lri_chan_state_t state_ff;
    lri_chan_state_t nxt_state;

    always_comb
    begin
        logic mark;
        logic viol;
        logic sat;
        logic d_pos;
        logic d_neg;
        logic d_los;
        d_pos = 1'b0;
        d_neg = 1'b0;
        mark = ch.bit_pos | ch.bit_neg;
        sat = &state_ff.cnt;
        // A pulse on both rails at once or a repeated polarity breaks the alternate mark rule.
        viol = (ch.bit_pos & ch.bit_neg)
             | (mark & ~(ch.bit_pos & ch.bit_neg) & state_ff.has_mark & (ch.bit_neg == state_ff.last_neg))
             | (~mark & (state_ff.zeros >= EXZ_CNT));
        d_los = mark ? 1'b0 : (state_ff.zeros >= LOS_CNT ? 1'b1 : state_ff.los);
        if (ch.single_rail)
        begin
            d_pos = mark;
            d_neg = ch.ovf_sel ? sat : viol;
        end
        else
        begin
            d_pos = ch.bit_pos;
            d_neg = ch.bit_neg;
        end
        nxt_state = state_ff;
        if (ch.strobe)
        begin
            nxt_state.zeros = mark ? '0 : (state_ff.zeros == ZMAX ? ZMAX : state_ff.zeros + 1'b1);
            if (mark & ~(ch.bit_pos & ch.bit_neg))
            begin
                nxt_state.has_mark = 1'b1;
                nxt_state.last_neg = ch.bit_neg;
            end
            nxt_state.pend_pos = d_pos;
            nxt_state.pend_neg = d_neg;
            nxt_state.pend_los = d_los;
            if (viol && !sat)
            begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
            end
        end
        // While the receiver is on, the rail and loss outputs move only on the recovered edge chosen globally.
        if (ch.strobe && !ch.edge_sel)
        begin
            nxt_state.pos_out = d_pos;
            nxt_state.neg_out = d_neg;
            nxt_state.los = d_los;
        end
        else if (ch.fall && ch.edge_sel)
        begin
            nxt_state.pos_out = state_ff.pend_pos;
            nxt_state.neg_out = state_ff.pend_neg;
            nxt_state.los = state_ff.pend_los;
        end
        if (ch.cnt_clr)
        begin
            nxt_state.cnt = '0;
        end
        if (!ch.rx_en)
        begin
            nxt_state = '0;
            nxt_state.cnt = state_ff.cnt;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign ch.pos_out = state_ff.pos_out;
    assign ch.neg_out = state_ff.neg_out;
    assign ch.los = state_ff.los;
    assign ch.sat = &state_ff.cnt;
endmodule // lri_channel

// >>> hdl/lri_receive_top.sv
// Receive output interface for eight line channels with clock recovery and a register port.
// Assumes sliced line pulses from the analog front end and a master on the core clock.
`timescale 1ns/100ps
module lri_receive_top #(
    parameter int unsigned BIT_DIV = lri_pkg::BIT_DIV,
    parameter int unsigned PH_W = lri_pkg::PH_W,
    parameter int unsigned LOS_ZEROS = lri_pkg::LOS_ZEROS,
    parameter int unsigned EXZ_LIMIT = lri_pkg::EXZ_LIMIT,
    parameter int unsigned CNT_W = lri_pkg::CNT_W
)(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic receiver_enable_in,
    input wire logic [lri_pkg::NUM_CH-1:0] line_input_positive,
    input wire logic [lri_pkg::NUM_CH-1:0] line_input_negative,
    output logic [lri_pkg::NUM_CH-1:0] rclk_out,
    output logic [lri_pkg::NUM_CH-1:0] positive_rail_data_out,
    output logic [lri_pkg::NUM_CH-1:0] negative_rail_data_out,
    output logic [lri_pkg::NUM_CH-1:0] loss_of_signal_out,
    output logic irq,
    input wire logic [lri_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lri_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lri_pkg::DATA_W-1:0] reg_rdata
);
    localparam int unsigned NCH = lri_pkg::NUM_CH;
    localparam int unsigned DW = lri_pkg::DATA_W;
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(BIT_DIV - 1);
    localparam logic [PH_W-1:0] PH_HALF = PH_W'(BIT_DIV / 2);
    localparam logic [PH_W-1:0] PH_ONE = PH_W'(1);

    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic [NCH-1:0] pos_s1;
        logic [NCH-1:0] pos_s2;
        logic [NCH-1:0] neg_s1;
        logic [NCH-1:0] neg_s2;
        logic [NCH-1:0] mark_d;
        logic [NCH-1:0][PH_W-1:0] phase;
        logic [NCH-1:0] seen_pos;
        logic [NCH-1:0] seen_neg;
        logic [NCH-1:0] bit_pos;
        logic [NCH-1:0] bit_neg;
        logic [NCH-1:0] strobe;
        logic [NCH-1:0] fall;
        logic [NCH-1:0] rclk;
        logic [DW-1:0] ctrl;
        logic [DW-1:0] int_status;
        logic [DW-1:0] int_enable;
        logic [DW-1:0] cnt_clr;
        logic [NCH-1:0] los_prev;
        logic [DW-1:0] rdata;
        logic irq;
    } lri_top_state_t;

    lri_top_state_t state_ff;
    lri_top_state_t nxt_state;

    logic [NCH-1:0] ch_pos;
    logic [NCH-1:0] ch_neg;
    logic [NCH-1:0] ch_los;
    logic [NCH-1:0] ch_sat;

    lri_chan_if ch_if[NCH]();

    function automatic logic reg_hit(input logic [lri_pkg::ADDR_W-1:0] addr, input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction

    // Clock recovery, one phase counter per channel on the core clock.
    always_comb
    begin
        logic mark_now;
        logic mark_edge;
        logic [PH_W-1:0] ph;
        mark_now = 1'b0;
        mark_edge = 1'b0;
        ph = '0;
        nxt_state = state_ff;
        nxt_state.en_s1 = receiver_enable_in;
        nxt_state.en_s2 = state_ff.en_s1;
        nxt_state.pos_s1 = line_input_positive;
        nxt_state.pos_s2 = state_ff.pos_s1;
        nxt_state.neg_s1 = line_input_negative;
        nxt_state.neg_s2 = state_ff.neg_s1;
        for (int i = 0; i < NCH; i++)
        begin
            // A switched-off receiver sees no pulses at all.
            mark_now = (state_ff.pos_s2[i] | state_ff.neg_s2[i]) & state_ff.en_s2;
            mark_edge = mark_now & ~state_ff.mark_d[i];
            nxt_state.mark_d[i] = mark_now;
            nxt_state.strobe[i] = 1'b0;
            nxt_state.fall[i] = 1'b0;
            ph = state_ff.phase[i];
            if ((mark_edge && ph >= PH_HALF) || ph == PH_LAST)
            begin
                // Bit boundary: hand over the finished bit and raise the clock.
                nxt_state.phase[i] = '0;
                nxt_state.rclk[i] = 1'b1;
                nxt_state.strobe[i] = 1'b1;
                nxt_state.bit_pos[i] = state_ff.seen_pos[i];
                nxt_state.bit_neg[i] = state_ff.seen_neg[i];
                nxt_state.seen_pos[i] = state_ff.pos_s2[i] & state_ff.en_s2;
                nxt_state.seen_neg[i] = state_ff.neg_s2[i] & state_ff.en_s2;
            end
            else
            begin
                // A pulse early in the bit pulls the phase back to the pulse start.
                if (mark_edge && ph != '0)
                begin
                    nxt_state.phase[i] = PH_ONE;
                end
                else
                begin
                    nxt_state.phase[i] = ph + PH_ONE;
                end
                if (nxt_state.phase[i] == PH_HALF)
                begin
                    nxt_state.rclk[i] = 1'b0;
                    nxt_state.fall[i] = 1'b1;
                end
                nxt_state.seen_pos[i] = state_ff.seen_pos[i] | (state_ff.pos_s2[i] & state_ff.en_s2);
                nxt_state.seen_neg[i] = state_ff.seen_neg[i] | (state_ff.neg_s2[i] & state_ff.en_s2);
            end
        end

        // Register writes.
        nxt_state.cnt_clr = '0;
        if (reg_wr)
        begin
            if (reg_hit(reg_addr, lri_pkg::REG_CTRL))
            begin
                nxt_state.ctrl = reg_wdata & lri_pkg::CTRL_MASK;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_INT_CLEAR))
            begin
                nxt_state.int_status = state_ff.int_status & ~reg_wdata;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_INT_ENABLE))
            begin
                nxt_state.int_enable = reg_wdata;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_CNT_RESET))
            begin
                nxt_state.cnt_clr = reg_wdata;
            end
        end

        // A loss event in the same cycle as its clear still lands.
        nxt_state.los_prev = ch_los;
        nxt_state.int_status = nxt_state.int_status | (ch_los & ~state_ff.los_prev);
        nxt_state.irq = |(nxt_state.int_status & nxt_state.int_enable);

        // Read data stands for exactly one cycle after the strobe.
        nxt_state.rdata = '0;
        if (reg_rd)
        begin
            if (reg_hit(reg_addr, lri_pkg::REG_CTRL))
            begin
                nxt_state.rdata = state_ff.ctrl;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_LOS))
            begin
                nxt_state.rdata = ch_los;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_INT_STATUS))
            begin
                nxt_state.rdata = state_ff.int_status;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_INT_ENABLE))
            begin
                nxt_state.rdata = state_ff.int_enable;
            end
            else if (reg_hit(reg_addr, lri_pkg::REG_SAT))
            begin
                nxt_state.rdata = ch_sat;
            end
            else
            begin
                nxt_state.rdata = '0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= '0;
            state_ff.ctrl <= lri_pkg::CTRL_RESET;
            state_ff.int_enable <= lri_pkg::INT_ENABLE_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // The channels share the global settings but each follows only its own recovered edges.
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        assign ch_if[g].strobe = state_ff.strobe[g];
        assign ch_if[g].fall = state_ff.fall[g];
        assign ch_if[g].bit_pos = state_ff.bit_pos[g];
        assign ch_if[g].bit_neg = state_ff.bit_neg[g];
        assign ch_if[g].rx_en = state_ff.en_s2;
        assign ch_if[g].edge_sel = state_ff.ctrl[lri_pkg::CTRL_EDGE_BIT];
        assign ch_if[g].single_rail = state_ff.ctrl[lri_pkg::CTRL_SINGLE_BIT];
        assign ch_if[g].ovf_sel = state_ff.ctrl[lri_pkg::CTRL_OVF_BIT];
        assign ch_if[g].cnt_clr = state_ff.cnt_clr[g];
        assign ch_pos[g] = ch_if[g].pos_out;
        assign ch_neg[g] = ch_if[g].neg_out;
        assign ch_los[g] = ch_if[g].los;
        assign ch_sat[g] = ch_if[g].sat;

        lri_channel #(
            .LOS_ZEROS(LOS_ZEROS),
            .EXZ_LIMIT(EXZ_LIMIT),
            .CNT_W(CNT_W)
        ) u_channel (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .ch(ch_if[g])
        );
    end

    assign rclk_out = state_ff.rclk;
    assign positive_rail_data_out = ch_pos;
    assign negative_rail_data_out = ch_neg;
    assign loss_of_signal_out = ch_los;
    assign irq = state_ff.irq;
    assign reg_rdata = state_ff.rdata;
endmodule // lri_receive_top

// >>> test/lri_assertions.sv
// Checker for the receive output interface, seeing only its top ports.
// Assumes one core clock domain and the package register map.
`timescale 1ns/100ps
module lri_checker #(
    parameter int unsigned BIT_DIV = lri_pkg::BIT_DIV
)(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic receiver_enable_in,
    input wire logic [lri_pkg::NUM_CH-1:0] rclk_out,
    input wire logic [lri_pkg::NUM_CH-1:0] positive_rail_data_out,
    input wire logic [lri_pkg::NUM_CH-1:0] negative_rail_data_out,
    input wire logic [lri_pkg::NUM_CH-1:0] loss_of_signal_out,
    input wire logic [lri_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lri_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [lri_pkg::DATA_W-1:0] reg_rdata
);
    localparam int unsigned HOLD = 2 * BIT_DIV + 4;
    logic [2:0] ctrl_ff;
    logic [2:0] on_ff;
    logic [15:0] quiet_ff;
    logic [15:0] age_ff;
    logic ok;
    // Checks under the default disable pause while the receivers are off, since the rail and loss outputs are then forced low.
    assign ok = rst_n && on_ff == 3'h4;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= 3'h0;
            on_ff <= 3'h0;
            quiet_ff <= 16'h0000;
            age_ff <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == lri_pkg::REG_CTRL)
            begin
                ctrl_ff <= reg_wdata[2:0];
            end
            on_ff <= !receiver_enable_in ? 3'h0 : (on_ff == 3'h4 ? on_ff : on_ff + 3'h1);
            quiet_ff <= $changed(rclk_out[0]) ? 16'h0000 : quiet_ff + 16'h0001;
            if (reg_wr && (reg_addr == lri_pkg::REG_CTRL || reg_addr == lri_pkg::REG_CNT_RESET))
            begin
                age_ff <= 16'h0000;
            end
            else if (age_ff != 16'(HOLD))
            begin
                age_ff <= age_ff + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!ok);
    sequence s_rose_ago(c);
        $past(rclk_out[c]) && !$past(rclk_out[c], 2);
    endsequence
    sequence s_fell_ago(c);
        !$past(rclk_out[c]) && $past(rclk_out[c], 2);
    endsequence
    property p_update(c);
        $changed({positive_rail_data_out[c], negative_rail_data_out[c]}) |->
            if (ctrl_ff[0]) s_fell_ago(c) else s_rose_ago(c);
    endproperty
    a_edge_update_ch0: assert property (p_update(0)) else $error("ch0 moved off edge");
    a_edge_update_ch7: assert property (p_update(7)) else $error("ch7 moved off edge");
    a_rx_off_quiet: assert property (disable iff (!rst_n) !receiver_enable_in [*5] |->
        (positive_rail_data_out | negative_rail_data_out | loss_of_signal_out) == 8'h00) else $error("live when off");
    a_rclk_free_run: assert property (disable iff (!rst_n) quiet_ff < 16'(HOLD)) else $error("rclk stopped");
    a_los_min_width: assert property ($rose(loss_of_signal_out[0]) |=> loss_of_signal_out[0] [*8])
        else $error("loss pulse short");
    a_ctrl_read_back: assert property (reg_rd && reg_addr == lri_pkg::REG_CTRL |=>
        reg_rdata == {5'h00, $past(ctrl_ff)}) else $error("ctrl readback");
    a_rdata_idle_zero: assert property (disable iff (!rst_n) !reg_rd |=> reg_rdata == 8'h00)
        else $error("rdata not idle");
    a_ovf_stays_high: assert property (ctrl_ff[2:1] == 2'h3 && age_ff == 16'(HOLD) &&
        negative_rail_data_out[0] |=> negative_rail_data_out[0]) else $error("overflow dropped");
endmodule // lri_checker

bind lri_receive_top lri_checker #(.BIT_DIV(BIT_DIV)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .receiver_enable_in(receiver_enable_in), .rclk_out(rclk_out), .positive_rail_data_out(positive_rail_data_out),
    .negative_rail_data_out(negative_rail_data_out), .loss_of_signal_out(loss_of_signal_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// >>> test/lri_framer_model.sv
// Framer-side model: samples every channel's rails on the edge opposite the update edge.
// Assumes it runs on the core clock and is told the edge selection.
`timescale 1ns/100ps
module lri_framer_model (
    input wire logic core_clk,
    input wire logic edge_sel,
    input wire logic [7:0] rclk,
    input wire logic [7:0] pos,
    input wire logic [7:0] neg,
    output logic [7:0] pos_q,
    output logic [7:0] neg_q,
    output logic [7:0] ncap
);
    logic [7:0] prev;
    // The capture count starts from zero so that the bench can take differences of it.
    logic [7:0] cap_ff = 8'h00;
    assign ncap = cap_ff;
    // Sampling half a bit away from the update edge keeps the rails settled.
    always @(posedge core_clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (prev[i] != rclk[i] && rclk[i] == edge_sel)
            begin
                pos_q[i] <= pos[i];
                neg_q[i] <= neg[i];
            end
        end
        if (prev[0] != rclk[0] && rclk[0] == edge_sel)
        begin
            cap_ff <= cap_ff + 8'h01;
        end
        prev <= rclk;
    end
endmodule // lri_framer_model

// >>> test/testbench.sv
// Self-checking bench of the receive output interface with a framer-side model.
// Assumes shortened counts: 16-cycle bits, loss after 8 zeros, 4-bit counters.
`timescale 1ns/100ps
module testbench;
    localparam int BD = 16;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_en = 1'b1;
    logic esel = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] lp = 8'h00;
    logic [7:0] ln = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] rclk, pos, neg, los, rdata, pq, nq, ncap;
    logic irq;
    int errors = 0;
    int checked = 0;
    lri_receive_top #(.BIT_DIV(BD), .PH_W(8), .LOS_ZEROS(8), .EXZ_LIMIT(3), .CNT_W(4)) dut (.core_clk(core_clk),
        .rst_n(rst_n), .receiver_enable_in(rx_en), .line_input_positive(lp), .line_input_negative(ln),
        .rclk_out(rclk), .positive_rail_data_out(pos), .negative_rail_data_out(neg), .loss_of_signal_out(los),
        .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata));
    lri_framer_model fr (.core_clk(core_clk), .edge_sel(esel), .rclk(rclk), .pos(pos), .neg(neg), .pos_q(pq),
        .neg_q(nq), .ncap(ncap));
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        check(what, rdata, exp);
    endtask
    // Each bit is one short pulse per marked rail; bits within one call follow with no idle gaps, like a real line.
    task automatic bits(input logic [7:0] p, input logic [7:0] n, input int k);
        repeat (k)
        begin
            lp <= p;
            ln <= n;
            repeat (4) @(posedge core_clk);
            lp <= 8'h00;
            ln <= 8'h00;
            repeat (BD - 4) @(posedge core_clk);
        end
    endtask
    task automatic alt(input int k);
        repeat (k)
        begin
            bits(8'h00, 8'hFF, 1);
            bits(8'hFF, 8'h00, 1);
        end
    endtask
    task automatic t_regs();
        rdc(lri_pkg::REG_CTRL, 8'h00, "ctrl reset");
        rdc(lri_pkg::REG_INT_ENABLE, 8'h00, "enable reset");
        wr(8'hFC, 8'hFF);
        rdc(8'hFC, 8'h00, "unmapped");
        wr(lri_pkg::REG_CTRL, 8'hFF);
        rdc(lri_pkg::REG_CTRL, 8'h07, "ctrl width");
        rdc(lri_pkg::REG_INT_CLEAR, 8'h00, "write only");
        wr(lri_pkg::REG_CTRL, 8'h00);
    endtask
    task automatic t_lines();
        bits(8'h0F, 8'hF0, 12);
        check("dual pos", pq, 8'h0F);
        check("dual neg", nq, 8'hF0);
        wr(lri_pkg::REG_CTRL, 8'h01);
        esel <= 1'b1;
        bits(8'hF0, 8'h0F, 6);
        check("fall pos", pq, 8'hF0);
        check("fall neg", nq, 8'h0F);
        wr(lri_pkg::REG_CTRL, 8'h02);
        esel <= 1'b0;
        alt(4);
        check("nrz", pq, 8'hFF);
        check("clean", nq, 8'h00);
        bits(8'hFF, 8'h00, 4);
        check("bipolar", nq, 8'hFF);
        bits(8'h00, 8'h00, 7);
        check("zeros", nq, 8'hFF);
        check("nrz zero", pq, 8'h00);
        alt(3);
        check("viol end", nq, 8'h00);
    endtask
    task automatic t_ovf();
        wr(lri_pkg::REG_CNT_RESET, 8'hFF);
        wr(lri_pkg::REG_CTRL, 8'h06);
        bits(8'hFF, 8'h00, 18);
        check("overflow", nq, 8'hFF);
        rdc(lri_pkg::REG_SAT, 8'hFF, "sat");
        wr(lri_pkg::REG_CNT_RESET, 8'h0F);
        alt(2);
        check("ovf split", nq, 8'hF0);
        rdc(lri_pkg::REG_SAT, 8'hF0, "sat split");
        wr(lri_pkg::REG_CTRL, 8'h00);
    endtask
    task automatic t_los();
        logic [7:0] c0;
        wr(lri_pkg::REG_INT_ENABLE, 8'h01);
        wr(lri_pkg::REG_INT_CLEAR, 8'hFF);
        c0 = ncap;
        bits(8'h00, 8'h00, 14);
        check("loss", los, 8'hFF);
        check("free rclk", {7'h00, ncap - c0 >= 8'h0C}, 8'h01);
        rdc(lri_pkg::REG_LOS, 8'hFF, "loss reg");
        rdc(lri_pkg::REG_INT_STATUS, 8'hFF, "status");
        check("irq on", {7'h00, irq}, 8'h01);
        wr(lri_pkg::REG_INT_ENABLE, 8'h00);
        @(posedge core_clk);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(lri_pkg::REG_INT_CLEAR, 8'hFF);
        rdc(lri_pkg::REG_INT_STATUS, 8'h00, "cleared");
        bits(8'h0F, 8'hF0, 3);
        check("loss gone", los, 8'h00);
        rx_en <= 1'b0;
        c0 = ncap;
        bits(8'hFF, 8'h00, 10);
        check("off data", pos, 8'h00);
        check("off loss", los, 8'h00);
        check("off rclk", {7'h00, ncap - c0 >= 8'h08}, 8'h01);
        rx_en <= 1'b1;
        bits(8'hFF, 8'h00, 4);
        check("on data", pq, 8'hFF);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_lines();
        t_ovf();
        t_los();
        give_verdict();
    end
endmodule // testbench
